// ### rtl/sdt_unit.sv
// single-register load/store execution unit with apb register access
// assumes an external memory on a req/ack bus from another clock domain
//
// Summary of operation
// RQ1 - offset is a 12-bit immediate or a possibly shifted second register
// RQ2 - add flag set adds offset to base, clear subtracts it
// RQ3 - pre-index flag uses modified base as address, else unmodified base
// RQ4 - pre-indexed transfers write back modified base only when refresh flag set
// RQ5 - post-indexed transfers always write back the modified base
// RQ6 - post-indexed with refresh flag in non-user mode drives user_xlate_n low
// RQ7 - only constant shift amounts allowed; register shift amounts are rejected
// RQ8 - byte flag set moves one byte, clear moves a 32-bit word
// RQ9 - words are little-endian: low byte at lowest address
// RQ10 - byte load takes addressed lane into low byte, upper bits zero
// RQ11 - byte store replicates low byte on all four lanes; memory picks lane
// RQ12 - unaligned word load rotates addressed byte into bits 7:0
// RQ13 - transfers never alter the status flags in the pc word
// RQ14 - pc as base gives pc+8 without flags; as offset pc+8 with flags
// RQ15 - pc stored as source gives pc+12 with flags
// RQ16 - load into pc changes only pc bits, flags kept
// RQ17 - any of address bits 31:26 set suppresses transfer, address exception
// RQ18 - only the address actually used is range-checked, not written-back base
// RQ19 - memory fault blocks all state change and flags a data abort
// RQ20 - enabled cache hit serves a load, otherwise external memory is read
// RQ21 - every store performs an external write cycle at once
// RQ22 - unaborted store updates a cached copy unless updating is switched off
`timescale 1ns/1ps
`include "sdt_regs.svh"

module sdt_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic mem_req,
   output logic mem_we,
   output logic mem_byte,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic user_xlate_n,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic memory_fault_in
);

   sdt_pkg::sdt_regs_s s;
   sdt_pkg::sdt_regs_s next_s;

   logic busy;
   logic [23:0] pc8;
   logic [23:0] pc12;
   logic [31:0] base_val;
   logic [31:0] offs_reg;
   logic [31:0] offs_val;
   logic [31:0] moved;
   logic [31:0] wb_val;
   logic [31:0] xaddr;
   logic [31:0] src_val;
   logic [31:0] data_in;
   logic [31:0] ld_val;
   logic [21:0] tag;
   logic [1:0] idx;
   logic hit;
   logic is_load;
   logic is_pre;
   logic bad_sh;
   logic range_bad;
   logic start;
   logic commit;
   logic wr_acc;
   logic [31:0] rd_mux;
   logic rd_hit;

   // barrel shift of the register offset with constant amount
   function automatic logic [31:0] shift_ofs(input logic [31:0] v, input logic [1:0] typ,
                                             input logic [4:0] amt, input logic c);
      logic [5:0] inv;
      inv = 6'h20 - {1'b0, amt};
      case (typ)
         2'b00: shift_ofs = v << amt;
         2'b01: shift_ofs = (amt == 5'h00) ? 32'h0000_0000 : v >> amt;
         2'b10: shift_ofs = (amt == 5'h00) ? {32{v[31]}} : 32'($signed(v) >>> amt);
         default: shift_ofs = (amt == 5'h00) ? {c, v[31:1]} : ((v >> amt) | (v << inv));
      endcase
   endfunction

   // address arithmetic and operand selection
   always_comb begin
      busy = (s.st != sdt_pkg::ST_IDLE);
      is_load = s.instr[`SDT_I_LOAD];
      is_pre = s.instr[`SDT_I_PRE];
      pc8 = s.pcw[25:2] + 24'h00_0002;
      pc12 = s.pcw[25:2] + 24'h00_0003;
      // pc as base carries no flags, as offset it does
      base_val = (s.instr[`SDT_I_RN_HI:`SDT_I_RN_LO] == `SDT_PC_IDX) ? {6'h00, pc8, 2'h0} : s.base; // RQ14
      offs_reg = (s.instr[3:0] == `SDT_PC_IDX) ? {s.pcw[31:26], pc8, s.pcw[1:0]} : s.offs; // RQ14
      // immediate or shifted register offset
      offs_val = s.instr[`SDT_I_REGOFS] ?
                 shift_ofs(offs_reg, s.instr[6:5], s.instr[11:7], s.pcw[29]) :
                 {20'h0_0000, s.instr[11:0]}; // RQ1
      bad_sh = s.instr[`SDT_I_REGOFS] & s.instr[`SDT_I_SREG]; // RQ7
      moved = s.instr[`SDT_I_UP] ? base_val + offs_val : base_val - offs_val; // RQ2
      wb_val = moved;
      xaddr = is_pre ? moved : base_val; // RQ3
      range_bad = |xaddr[31:26]; // RQ17 RQ18
      // stored pc is twelve ahead and carries the flags
      src_val = (s.instr[`SDT_I_RD_HI:`SDT_I_RD_LO] == `SDT_PC_IDX) ?
                {s.pcw[31:26], pc12, s.pcw[1:0]} : s.xfer; // RQ15
      tag = xaddr[25:4];
      idx = xaddr[3:2];
      hit = s.cvalid[idx] & (s.ctag[idx] == tag);
      start = (s.st == sdt_pkg::ST_IDLE) & s.go & ~bad_sh & ~range_bad;
      data_in = (s.st == sdt_pkg::ST_BUS) ? s.rd_s2 : s.cdata[idx];
      commit = (start & is_load & s.cache_en & hit) |
               ((s.st == sdt_pkg::ST_BUS) & s.ack_s2 & ~s.flt_s2); // RQ19
   end

   // load data alignment: lane pick for bytes, rotation for words
   always_comb begin
      if (s.instr[`SDT_I_BYTE]) begin
         case (xaddr[1:0])
            2'b00: ld_val = {24'h00_0000, data_in[7:0]}; // RQ10 RQ9
            2'b01: ld_val = {24'h00_0000, data_in[15:8]};
            2'b10: ld_val = {24'h00_0000, data_in[23:16]};
            default: ld_val = {24'h00_0000, data_in[31:24]};
         endcase
      end else begin
         case (xaddr[1:0])
            2'b00: ld_val = data_in;
            2'b01: ld_val = {data_in[7:0], data_in[31:8]}; // RQ12
            2'b10: ld_val = {data_in[15:0], data_in[31:16]};
            default: ld_val = {data_in[23:0], data_in[31:24]};
         endcase
      end
   end

   // register read mux and decode
   always_comb begin
      rd_hit = 1'b1;
      if (paddr == `SDT_OFF_INSTR) begin
         rd_mux = s.instr;
      end else if (paddr == `SDT_OFF_BASE) begin
         rd_mux = s.base;
      end else if (paddr == `SDT_OFF_OFFS) begin
         rd_mux = s.offs;
      end else if (paddr == `SDT_OFF_XFER) begin
         rd_mux = s.xfer;
      end else if (paddr == `SDT_OFF_PCW) begin
         rd_mux = s.pcw;
      end else if (paddr == `SDT_OFF_CTRL) begin
         rd_mux = {27'h000_0000, 1'b0, s.upd_off, s.cache_en, s.user_mode, s.go};
      end else if (paddr == `SDT_OFF_STAT) begin
         rd_mux = {27'h000_0000, s.bad_shift, s.data_abort, s.addr_exc, s.done, busy};
      end else if (paddr == `SDT_OFF_ADDR) begin
         rd_mux = s.last_addr;
      end else begin
         rd_mux = 32'h0000_0000;
         rd_hit = 1'b0;
      end
   end

   // next state: apb, synchronisers, transfer sequencing, cache
   always_comb begin
      next_s = s;
      wr_acc = psel & penable & s.pready & pwrite & ~s.pslverr;
      next_s.ack_s1 = mem_ack;
      next_s.ack_s2 = s.ack_s1;
      next_s.flt_s1 = memory_fault_in;
      next_s.flt_s2 = s.flt_s1;
      next_s.rd_s1 = mem_rdata;
      next_s.rd_s2 = s.rd_s1;
      // one wait state, answer registered
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      if (psel & penable & ~s.pready) begin
         next_s.pready = 1'b1;
         next_s.prdata = pwrite ? 32'h0000_0000 : rd_mux;
         next_s.pslverr = ~rd_hit;
      end
      // writes to operand registers are ignored while busy
      if (wr_acc) begin
         if (paddr == `SDT_OFF_INSTR) begin
            if (!busy) next_s.instr = pwdata;
         end else if (paddr == `SDT_OFF_BASE) begin
            if (!busy) next_s.base = pwdata;
         end else if (paddr == `SDT_OFF_OFFS) begin
            if (!busy) next_s.offs = pwdata;
         end else if (paddr == `SDT_OFF_XFER) begin
            if (!busy) next_s.xfer = pwdata;
         end else if (paddr == `SDT_OFF_PCW) begin
            if (!busy) next_s.pcw = pwdata;
         end else if (paddr == `SDT_OFF_CTRL) begin
            next_s.user_mode = pwdata[`SDT_C_USER];
            next_s.cache_en = pwdata[`SDT_C_CEN];
            next_s.upd_off = pwdata[`SDT_C_UPDOFF];
            if (pwdata[`SDT_C_GO] & ~busy) next_s.go = 1'b1;
            if (pwdata[`SDT_C_FLUSH] & ~busy) next_s.cvalid = 4'h0;
         end else if (paddr == `SDT_OFF_STAT) begin
            // write one to clear; a same-cycle set below wins
            if (pwdata[`SDT_S_DONE]) next_s.done = 1'b0;
            if (pwdata[`SDT_S_AEXC]) next_s.addr_exc = 1'b0;
            if (pwdata[`SDT_S_ABORT]) next_s.data_abort = 1'b0;
            if (pwdata[`SDT_S_BADSH]) next_s.bad_shift = 1'b0;
         end
      end
      case (s.st)
         sdt_pkg::ST_IDLE: begin
            if (s.go) begin
               next_s.go = 1'b0;
               next_s.last_addr = xaddr;
               if (bad_sh) begin
                  next_s.bad_shift = 1'b1; // RQ7
                  next_s.done = 1'b1;
               end else if (range_bad) begin
                  next_s.addr_exc = 1'b1; // RQ17
                  next_s.done = 1'b1;
               end else if (is_load & s.cache_en & hit) begin
                  next_s.done = 1'b1; // RQ20
               end else begin
                  // stores always go out to memory
                  next_s.st = sdt_pkg::ST_BUS; // RQ21 RQ20
                  next_s.mem_req = 1'b1;
                  next_s.mem_we = ~is_load;
                  next_s.mem_byte = s.instr[`SDT_I_BYTE]; // RQ8
                  next_s.mem_addr = xaddr;
                  next_s.mem_wdata = s.instr[`SDT_I_BYTE] ? {4{src_val[7:0]}} : src_val; // RQ11
                  next_s.user_xlate_n = ~(s.user_mode | (~is_pre & s.instr[`SDT_I_WB])); // RQ6
               end
            end
         end
         sdt_pkg::ST_BUS: begin
            if (s.ack_s2) begin
               next_s.mem_req = 1'b0;
               next_s.mem_we = 1'b0;
               next_s.user_xlate_n = 1'b1;
               next_s.st = sdt_pkg::ST_REL;
               next_s.done = 1'b1;
               if (s.flt_s2) next_s.data_abort = 1'b1; // RQ19
            end
         end
         sdt_pkg::ST_REL: begin
            // wait for the memory to drop its acknowledge
            if (!s.ack_s2) next_s.st = sdt_pkg::ST_IDLE;
         end
         default: next_s.st = sdt_pkg::ST_IDLE;
      endcase
      // commit of a completed transfer
      if (commit) begin
         if (is_load) begin
            if (s.instr[`SDT_I_RD_HI:`SDT_I_RD_LO] == `SDT_PC_IDX) begin
               next_s.pcw[25:2] = ld_val[25:2]; // RQ16 RQ13
            end else begin
               next_s.xfer = ld_val; // RQ10 RQ12
            end
            if ((s.st == sdt_pkg::ST_BUS) & s.cache_en & ~s.instr[`SDT_I_BYTE]) begin
               next_s.cvalid[idx] = 1'b1;
               next_s.ctag[idx] = tag;
               next_s.cdata[idx] = s.rd_s2;
            end
         end else if (hit & ~s.upd_off) begin
            // keep cache consistent even while disabled
            if (s.instr[`SDT_I_BYTE]) begin
               next_s.cdata[idx][8*xaddr[1:0] +: 8] = src_val[7:0]; // RQ22 RQ9
            end else begin
               next_s.cdata[idx] = src_val; // RQ22
            end
         end
         if (~is_pre | s.instr[`SDT_I_WB]) begin
            // base write-back; pc base keeps its flags
            if (s.instr[`SDT_I_RN_HI:`SDT_I_RN_LO] == `SDT_PC_IDX) begin
               next_s.pcw[25:2] = wb_val[25:2]; // RQ13
            end else begin
               next_s.base = wb_val; // RQ4 RQ5
            end
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.st <= sdt_pkg::ST_IDLE;
         s.user_xlate_n <= 1'b1;
         s.pcw <= `SDT_RST_WORD;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from flops
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign mem_req = s.mem_req;
   assign mem_we = s.mem_we;
   assign mem_byte = s.mem_byte;
   assign mem_addr = s.mem_addr;
   assign mem_wdata = s.mem_wdata;
   assign user_xlate_n = s.user_xlate_n;

   // no out-of-range address on the bus
   range_check_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
      s.mem_req |-> s.mem_addr[31:26] == 6'h00) else $error("illegal address driven");

   // fault at acknowledge leaves operands untouched
   abort_state_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
      (s.st == sdt_pkg::ST_BUS && s.ack_s2 && s.flt_s2) |=>
      ($stable(s.base) && $stable(s.xfer) && $stable(s.pcw) && s.data_abort))
      else $error("aborted transfer changed state");

   // a started store reaches the bus next cycle
   store_ext_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ21
      (start && !is_load) |=> (s.mem_req && s.mem_we)) else $error("store not written out");

   // byte store replicated on every lane
   byte_repl_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
      (s.mem_req && s.mem_we && s.mem_byte) |->
      (s.mem_wdata[31:24] == s.mem_wdata[7:0] && s.mem_wdata[23:16] == s.mem_wdata[7:0] &&
       s.mem_wdata[15:8] == s.mem_wdata[7:0])) else $error("byte store not replicated");

   // post-indexed refresh forces user translation
   xlate_low_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      (s.mem_req && !s.instr[`SDT_I_PRE] && s.instr[`SDT_I_WB]) |-> !s.user_xlate_n)
      else $error("translation pin not low");

   // flags in the pc word change only by software write
   psr_kept_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
      !(wr_acc && paddr == `SDT_OFF_PCW) |=> ($stable(s.pcw[31:26]) && $stable(s.pcw[1:0])))
      else $error("status flags modified");

   // byte load clears upper bits of transfer register
   byte_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
      (commit && is_load && s.instr[`SDT_I_BYTE] && s.instr[15:12] != `SDT_PC_IDX) |=>
      s.xfer[31:8] == 24'h00_0000) else $error("byte load upper bits not zero");

   // post-indexed transfer writes back base
   post_wb_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      (commit && !s.instr[`SDT_I_PRE] && s.instr[19:16] != `SDT_PC_IDX) |=>
      s.base == $past(wb_val)) else $error("post-indexed base not written back");

   // enabled cache hit serves a load without a bus cycle
   cache_hit_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
      (start && is_load && s.cache_en && hit) |=> (!s.mem_req && s.done))
      else $error("cache hit went to memory");

   // apb answer lasts one cycle
   rdy_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.pready |=> !s.pready) else $error("ready held");

   // error only with ready
   err_rdy_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.pslverr |-> s.pready) else $error("error without ready");

   // translation pin idles high
   xlate_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      !s.mem_req |-> s.user_xlate_n) else $error("pin low while idle");

   // register shift refused
   shift_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
      (s.go && bad_sh && !busy) |=> (!s.mem_req && s.bad_shift)) else $error("shift not refused");

   // bad address refused
   range_exc_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
      (s.go && range_bad && !bad_sh && !busy) |=> (!s.mem_req && s.addr_exc)) else $error("no exception");

endmodule

// ### rtl/sdt_regs.svh
// register offsets, field positions and reset values of the single data transfer unit
// assumes an apb slave with 8-bit byte addresses and 32-bit data
`ifndef SDT_REGS_SVH
`define SDT_REGS_SVH

// register byte offsets
`define SDT_OFF_INSTR 8'h00
`define SDT_OFF_BASE 8'h04
`define SDT_OFF_OFFS 8'h08
`define SDT_OFF_XFER 8'h0C
`define SDT_OFF_PCW 8'h10
`define SDT_OFF_CTRL 8'h14
`define SDT_OFF_STAT 8'h18
`define SDT_OFF_ADDR 8'h1C

// instruction word fields
`define SDT_I_REGOFS 25
`define SDT_I_PRE 24
`define SDT_I_UP 23
`define SDT_I_BYTE 22
`define SDT_I_WB 21
`define SDT_I_LOAD 20
`define SDT_I_RN_HI 19
`define SDT_I_RN_LO 16
`define SDT_I_RD_HI 15
`define SDT_I_RD_LO 12
`define SDT_I_SREG 4
`define SDT_PC_IDX 4'hF

// control register bits
`define SDT_C_GO 0
`define SDT_C_USER 1
`define SDT_C_CEN 2
`define SDT_C_UPDOFF 3
`define SDT_C_FLUSH 4

// status register bits
`define SDT_S_BUSY 0
`define SDT_S_DONE 1
`define SDT_S_AEXC 2
`define SDT_S_ABORT 3
`define SDT_S_BADSH 4

// reset values
`define SDT_RST_WORD 32'h0000_0000
`define SDT_RST_CTRL 4'h0

`endif

// ### rtl/sdt_pkg.sv
// types of the single data transfer unit
// assumes sdt_regs.svh supplies the numeric constants
package sdt_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUS = 2'b01,
      ST_REL = 2'b10
   } sdt_state_e;

   typedef struct packed {
      sdt_state_e st;
      logic [31:0] instr;
      logic [31:0] base;
      logic [31:0] offs;
      logic [31:0] xfer;
      logic [31:0] pcw;
      logic user_mode;
      logic cache_en;
      logic upd_off;
      logic go;
      logic done;
      logic addr_exc;
      logic data_abort;
      logic bad_shift;
      logic [31:0] last_addr;
      logic mem_req;
      logic mem_we;
      logic mem_byte;
      logic user_xlate_n;
      logic [31:0] mem_addr;
      logic [31:0] mem_wdata;
      logic ack_s1;
      logic ack_s2;
      logic flt_s1;
      logic flt_s2;
      logic [31:0] rd_s1;
      logic [31:0] rd_s2;
      logic [3:0] cvalid;
      logic [3:0][21:0] ctag;
      logic [3:0][31:0] cdata;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sdt_regs_s;

endpackage

// ### sim/sdt_mem_model.sv
// behavioural external memory answering the unit's transfer bus
// assumes the unit holds its request until ack is seen, then drops it
`timescale 1ns/1ps
module sdt_mem_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic req,
   input wire logic we,
   input wire logic byte_op,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [3:0] dly,
   input wire logic flt_en,
   output logic ack,
   output logic [31:0] rdata,
   output logic fault
);
   logic [31:0] mem [16];
   logic [4:0] cnt;

   // answer dly+1 cycles after req is first seen; read data settles one cycle before ack
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack <= 1'b0;
         fault <= 1'b0;
         cnt <= 5'h00;
         rdata <= 32'h0;
      end else if (req && !ack) begin
         cnt <= cnt + 5'h01;
         if (cnt == {1'b0, dly}) begin
            rdata <= mem[addr[5:2]];
         end
         if (cnt == {1'b0, dly} + 5'h01) begin
            ack <= 1'b1;
            fault <= flt_en;
            for (int i = 0; i < 4; i++) begin
               if (we && !flt_en && (!byte_op || addr[1:0] == i[1:0])) begin
                  mem[addr[5:2]][8*i +: 8] <= wdata[8*i +: 8];
               end
            end
         end
      end else if (ack && !req) begin
         ack <= 1'b0;
         fault <= 1'b0;
         cnt <= 5'h00;
         rdata <= ~rdata; // released bus shows no stale value
      end
   end
endmodule

// ### sim/single_data_transfer_unit_tb_top.sv
// self-checking bench for the single data transfer unit
// assumes sdt_unit with apb registers and the behavioural memory model
`timescale 1ns/1ps
`include "sdt_regs.svh"
module single_data_transfer_unit_tb_top;
   typedef struct {logic [31:0] v; logic [31:0] m; logic e;} sdt_rd_s;
   typedef struct {logic we; logic b; logic [31:0] a; logic [31:0] d; logic xn;} sdt_bus_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, req_d, flt_en;
   logic mem_req, mem_we, mem_byte, user_xlate_n, mem_ack, memory_fault_in;
   logic [7:0] paddr;
   logic [3:0] dly;
   logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, r, w, pw, lw, sw;
   logic [63:0] q64;
   int error_cnt = 0;
   int n_compared = 0;
   sdt_rd_s rq[$];
   sdt_bus_s bq[$];
   sdt_bus_s b;

   always #12.5 pclk = ~pclk;

   sdt_unit u_sdt_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .user_xlate_n(user_xlate_n), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .memory_fault_in(memory_fault_in));
   sdt_mem_model u_sdt_mem_model (.clk(pclk), .rstn(presetn), .req(mem_req), .we(mem_we),
      .byte_op(mem_byte), .addr(mem_addr), .wdata(mem_wdata), .dly(dly), .flt_en(flt_en),
      .ack(mem_ack), .rdata(mem_rdata), .fault(memory_fault_in));

   task automatic miss(input string s);
      error_cnt++;
      $display("mismatch at %0t: %s", $time, s);
   endtask

   task automatic summarize();
      if (bq.size() != 0) miss("bus cycle missing");
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // one apb transfer: setup, access, hold until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
      logic [31:0] q;
      rq.push_back('{v, m, a > 8'h1C});
      apb(1'b0, a, 32'h0, q);
   endtask

   task automatic ck(input logic [7:0] a, input logic [31:0] v);
      rd(a, v, 32'hFFFF_FFFF);
   endtask

   // flags are {reg offset, pre, up, byte, write-back, load}
   function automatic logic [31:0] mk(input logic [5:0] f, input logic [3:0] rn, rd, input logic [11:0] o);
      return {4'hE, 2'b01, f, rn, rd, o};
   endfunction

   // load registers, start, poll status until idle with an outcome
   task automatic go(input logic [31:0] ins, bs, o = 32'h0, x = 32'h0, input logic [2:0] c = 3'b000);
      logic [31:0] q;
      int n;
      n = 0;
      dly <= 4'($urandom_range(6));
      wr(`SDT_OFF_STAT, 32'h1E);
      wr(`SDT_OFF_INSTR, ins);
      wr(`SDT_OFF_BASE, bs);
      wr(`SDT_OFF_OFFS, o);
      wr(`SDT_OFF_XFER, x);
      wr(`SDT_OFF_CTRL, {28'h0, c, 1'b1});
      do begin
         rq.push_back('{32'h0, 32'h0, 1'b0});
         apb(1'b0, `SDT_OFF_STAT, 32'h0, q);
         n++;
      end while ((q[0] !== 1'b0 || q[4:1] === 4'h0) && n < 30);
      if (n >= 30) miss("transfer hang");
   endtask

   // compare read responses and bus cycles against the oldest notes
   always @(posedge pclk) begin
      req_d <= mem_req;
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         n_compared++;
         if (rq.size() == 0) miss("unexpected read");
         else if (((prdata ^ rq[0].v) & rq[0].m) !== 32'h0 || pslverr !== rq[0].e) begin
            miss($sformatf("read %h from %h", prdata, paddr));
         end
         if (rq.size() != 0) void'(rq.pop_front());
      end
      if (mem_req === 1'b1 && req_d !== 1'b1) begin
         n_compared++;
         if (bq.size() == 0) miss("unexpected bus cycle");
         else begin
            b = bq.pop_front();
            if (b.we !== mem_we || b.b !== mem_byte || b.a !== mem_addr || b.xn !== user_xlate_n ||
               (b.we && b.d !== mem_wdata)) miss($sformatf("bus cycle at %h", mem_addr));
         end
      end
   end

   // watchdog
   initial begin
      #(25 * 20000);
      miss("watchdog");
      summarize();
   end

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      flt_en = 1'b0;
      dly = 4'h0;
      void'($urandom(61));
      for (int i = 0; i < 16; i++) u_sdt_mem_model.mem[i] = $urandom;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h20, 32'h0, 32'hFFFF_FFFF);
      // indexing, direction, write-back and translation pin
      w = $urandom;
      bq.push_back('{1'b1, 1'b0, 32'h18, w, 1'b1});
      go(mk(6'b011010, 4'h1, 4'h2, 12'h008), 32'h10, 32'h0, w);
      ck(`SDT_OFF_BASE, 32'h18);
      ck(`SDT_OFF_ADDR, 32'h18);
      bq.push_back('{1'b0, 1'b0, 32'h18, 32'h0, 1'b0});
      go(mk(6'b010001, 4'h1, 4'h2, 12'h004), 32'h1C, 32'h0, 32'h0, 3'b001);
      ck(`SDT_OFF_BASE, 32'h1C);
      ck(`SDT_OFF_XFER, w);
      w = u_sdt_mem_model.mem[2];
      bq.push_back('{1'b0, 1'b0, 32'h08, 32'h0, 1'b1});
      go(mk(6'b101001, 4'h1, 4'h2, 12'h103), 32'h08, 32'h3);
      ck(`SDT_OFF_BASE, 32'h14);
      ck(`SDT_OFF_XFER, w);
      bq.push_back('{1'b1, 1'b0, 32'h30, 32'h0, 1'b0});
      go(mk(6'b000010, 4'h1, 4'h2, 12'h010), 32'h30);
      ck(`SDT_OFF_BASE, 32'h20);
      // byte stores on each lane, then word and byte loads back
      for (int k = 0; k < 4; k++) begin
         w = $urandom;
         bq.push_back('{1'b1, 1'b1, 32'h20 + k, {4{w[7:0]}}, 1'b1});
         go(mk(6'b011100, 4'h1, 4'h2, 12'h000), 32'h20 + k, 32'h0, w);
         r[8*k +: 8] = w[7:0];
      end
      for (int k = 0; k < 4; k++) begin
         bq.push_back('{1'b0, 1'b1, 32'h20 + k, 32'h0, 1'b1});
         go(mk(6'b011101, 4'h1, 4'h2, 12'h000), 32'h20 + k);
         ck(`SDT_OFF_XFER, {24'h0, r[8*k +: 8]});
         bq.push_back('{1'b0, 1'b0, 32'h20 + k, 32'h0, 1'b1});
         go(mk(6'b011001, 4'h1, 4'h2, 12'h000), 32'h20 + k);
         q64 = {r, r} >> (8 * k);
         ck(`SDT_OFF_XFER, q64[31:0]);
      end
      // address range check on the used address only, then register shift refusal
      go(mk(6'b001001, 4'h1, 4'h2, 12'h000), 32'h0400_0000);
      rd(`SDT_OFF_STAT, 32'h4, 32'h1D);
      bq.push_back('{1'b0, 1'b0, 32'h10, 32'h0, 1'b1});
      go(mk(6'b110011, 4'h1, 4'h2, 12'h003), 32'h0400_0010, 32'h0400_0000);
      ck(`SDT_OFF_BASE, 32'h10);
      bq.push_back('{1'b0, 1'b0, 32'h3C, 32'h0, 1'b1});
      go(mk(6'b101001, 4'h1, 4'h2, 12'h003), 32'h3C, 32'h0400_0000);
      rd(`SDT_OFF_STAT, 32'h0, 32'h1D);
      go(mk(6'b111001, 4'h1, 4'h2, 12'h013), 32'h10, 32'h1);
      rd(`SDT_OFF_STAT, 32'h10, 32'h1D);
      // external abort leaves registers untouched
      w = $urandom;
      flt_en <= 1'b1;
      bq.push_back('{1'b0, 1'b0, 32'h04, 32'h0, 1'b1});
      go(mk(6'b011011, 4'h1, 4'h2, 12'h004), 32'h0, 32'h0, w);
      flt_en <= 1'b0;
      rd(`SDT_OFF_STAT, 32'h8, 32'h1D);
      ck(`SDT_OFF_BASE, 32'h0);
      ck(`SDT_OFF_XFER, w);
      // program counter as base, source, offset and destination
      pw = {6'h2A, 24'h00_0010, 2'b11};
      wr(`SDT_OFF_PCW, pw);
      bq.push_back('{1'b0, 1'b0, 32'h4C, 32'h0, 1'b1});
      go(mk(6'b011001, 4'hF, 4'h2, 12'h004), 32'h0);
      bq.push_back('{1'b1, 1'b0, 32'h10, {6'h2A, 24'h00_0013, 2'b11}, 1'b1});
      go(mk(6'b011000, 4'h1, 4'hF, 12'h000), 32'h10);
      bq.push_back('{1'b0, 1'b0, 32'h0, 32'h0, 1'b1});
      go(mk(6'b101001, 4'h1, 4'h2, 12'h00F), 32'h0);
      ck(`SDT_OFF_BASE, {6'h2A, 24'h00_0012, 2'b11});
      w = u_sdt_mem_model.mem[0];
      bq.push_back('{1'b0, 1'b0, 32'h0, 32'h0, 1'b1});
      go(mk(6'b011001, 4'h1, 4'hF, 12'h000), 32'h0);
      ck(`SDT_OFF_PCW, {pw[31:26], w[25:2], pw[1:0]});
      // cache fill, hit, store update and update switched off
      lw = mk(6'b011001, 4'h1, 4'h2, 12'h000);
      sw = mk(6'b011000, 4'h1, 4'h2, 12'h000);
      w = u_sdt_mem_model.mem[13];
      bq.push_back('{1'b0, 1'b0, 32'h34, 32'h0, 1'b1});
      go(lw, 32'h34, 32'h0, 32'h0, 3'b010);
      u_sdt_mem_model.mem[13] = ~w;
      go(lw, 32'h34, 32'h0, 32'h0, 3'b010);
      ck(`SDT_OFF_XFER, w);
      bq.push_back('{1'b0, 1'b0, 32'h34, 32'h0, 1'b1});
      go(lw, 32'h34);
      ck(`SDT_OFF_XFER, ~w);
      r = $urandom;
      bq.push_back('{1'b1, 1'b0, 32'h34, r, 1'b1});
      go(sw, 32'h34, 32'h0, r);
      go(lw, 32'h34, 32'h0, 32'h0, 3'b010);
      ck(`SDT_OFF_XFER, r);
      bq.push_back('{1'b1, 1'b0, 32'h34, ~r, 1'b1});
      go(sw, 32'h34, 32'h0, ~r, 3'b100);
      go(lw, 32'h34, 32'h0, 32'h0, 3'b010);
      ck(`SDT_OFF_XFER, r);
      // flush empties the cache, so the load goes out again
      wr(`SDT_OFF_CTRL, 32'h10);
      bq.push_back('{1'b0, 1'b0, 32'h34, 32'h0, 1'b1});
      go(lw, 32'h34, 32'h0, 32'h0, 3'b010);
      ck(`SDT_OFF_XFER, ~r);
      summarize();
   end
endmodule
